// >>> rtl/monitor_flag_latch_bank.sv
// Module: latched alarm, warning and init-done flags in bytes 6 to 14 of the map
`timescale 1ns/1ps
`default_nettype none
module monitor_flag_latch_bank #(
  parameter int LANES = flag_bank_pkg::LANES,
  parameter int VALUE_WIDTH = flag_bank_pkg::VALUE_WIDTH
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Module reset pin, asynchronous to clk
  input wire logic module_reset_pin_active_low,
  // Measurements from the monitor logic, same clock
  input wire logic [VALUE_WIDTH-1:0] temperature_value,
  input wire logic [VALUE_WIDTH-1:0] supply_value,
  input wire logic [LANES-1:0][VALUE_WIDTH-1:0] rx_power_value,
  input wire logic [LANES-1:0][VALUE_WIDTH-1:0] tx_bias_value,
  input wire logic [LANES-1:0][VALUE_WIDTH-1:0] tx_power_value,
  // Thresholds, index 3 high alarm, 2 low alarm, 1 high warning, 0 low warning
  input wire logic [3:0][VALUE_WIDTH-1:0] temperature_threshold,
  input wire logic [3:0][VALUE_WIDTH-1:0] supply_threshold,
  input wire logic [3:0][VALUE_WIDTH-1:0] rx_power_threshold,
  input wire logic [3:0][VALUE_WIDTH-1:0] tx_bias_threshold,
  input wire logic [3:0][VALUE_WIDTH-1:0] tx_power_threshold,
  // Init sequence status, level, same clock
  input wire logic init_sequence_done,
  // Byte read port from the two-wire management slave
  input wire logic read_strobe,
  input wire logic [7:0] read_addr,
  // Read answer
  output logic [7:0] read_data,
  output logic read_valid
);

  localparam int QUANTITIES = 2 + 3 * LANES;
  localparam int FLAG_BYTES = flag_bank_pkg::FLAG_BYTES;

  ////////////////////////////////////////////////////////////////////////////
  // Address decoding

  // True for an offset whose bits live in flip-flops
  function automatic logic is_flag_byte(input logic [7:0] addr);
    is_flag_byte = (addr >= flag_bank_pkg::FIRST_FLAG_BYTE) &&
      (addr <= flag_bank_pkg::LAST_FLAG_BYTE);
  endfunction

  // Index into the flag array for an offset in range
  function automatic logic [3:0] flag_index(input logic [7:0] addr);
    logic [7:0] diff;
    diff = addr - flag_bank_pkg::FIRST_FLAG_BYTE;
    flag_index = diff[3:0];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Module reset pin synchroniser

  logic [1:0] pin_sync;
  logic pin_reset_active;

  // The pin is asynchronous, so two flops before anything looks at it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_sync <= flag_bank_pkg::PIN_SYNC_RESET;
    end else begin
      pin_sync <= {pin_sync[0], module_reset_pin_active_low};
    end
  end

  assign pin_reset_active = !pin_sync[1];

  ////////////////////////////////////////////////////////////////////////////
  // Threshold comparison, one comparator per monitored quantity

  logic [QUANTITIES-1:0][VALUE_WIDTH-1:0] all_value;
  logic [QUANTITIES-1:0][3:0][VALUE_WIDTH-1:0] all_threshold;
  logic [QUANTITIES-1:0][3:0] all_condition;

  // Quantity 0 temperature, 1 supply, then rx power, tx bias, tx power lanes
  assign all_value = {tx_power_value, tx_bias_value, rx_power_value,
    supply_value, temperature_value};
  assign all_threshold = {{LANES{tx_power_threshold}}, {LANES{tx_bias_threshold}},
    {LANES{rx_power_threshold}}, supply_threshold, temperature_threshold};

  generate
    for (genvar q = 0; q < QUANTITIES; q++) begin : g_cmp
      monitor_cmp_if cmp_bus ();
      assign cmp_bus.value = all_value[q];
      assign cmp_bus.threshold = all_threshold[q];
      assign all_condition[q] = cmp_bus.condition;
      threshold_compare #(
        .SIGNED_VALUE(q == flag_bank_pkg::TEMPERATURE_Q)
      ) u_cmp (
        .bus(cmp_bus)
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Init-done event

  logic init_done_prev;
  logic init_done_event;

  // Only the finishing edge sets the flag, so a read can clear it for good
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      init_done_prev <= 1'b0;
    end else begin
      init_done_prev <= init_sequence_done;
    end
  end

  assign init_done_event = init_sequence_done && !init_done_prev;

  ////////////////////////////////////////////////////////////////////////////
  // Set terms for each held byte

  logic [FLAG_BYTES-1:0][7:0] set_term;
  logic [LANES-1:0][3:0] rx_cond;
  logic [LANES-1:0][3:0] bias_cond;
  logic [LANES-1:0][3:0] txp_cond;

  assign rx_cond = all_condition[flag_bank_pkg::RX_POWER_Q +: LANES];
  assign bias_cond = all_condition[flag_bank_pkg::TX_BIAS_Q +: LANES];
  assign txp_cond = all_condition[flag_bank_pkg::TX_POWER_Q +: LANES];

  // Module flags: condition nibble high, reserved bits never set
  assign set_term[0] = {all_condition[flag_bank_pkg::TEMPERATURE_Q], 3'h0,
    init_done_event};
  assign set_term[1] = {all_condition[flag_bank_pkg::SUPPLY_Q], 4'h0};
  assign set_term[2] = 8'h00;
  // Lower-numbered lane in the upper nibble for every lane pair
  assign set_term[3] = {rx_cond[0], rx_cond[1]};
  assign set_term[4] = {rx_cond[2], rx_cond[3]};
  assign set_term[5] = {bias_cond[0], bias_cond[1]};
  assign set_term[6] = {bias_cond[2], bias_cond[3]};
  assign set_term[7] = {txp_cond[0], txp_cond[1]};
  assign set_term[8] = {txp_cond[2], txp_cond[3]};

  ////////////////////////////////////////////////////////////////////////////
  // Latched flag storage

  logic [FLAG_BYTES-1:0][7:0] flag_byte;
  logic [FLAG_BYTES-1:0][7:0] next_flag_byte;
  logic read_hits_flags;
  logic [3:0] read_index;

  assign read_hits_flags = read_strobe && is_flag_byte(read_addr);
  assign read_index = flag_index(read_addr);

  // A set in the clearing cycle wins, so no event is lost to a read
  generate
    for (genvar b = 0; b < FLAG_BYTES; b++) begin : g_flag
      logic clear_this;
      assign clear_this = pin_reset_active ||
        (read_hits_flags && (read_index == 4'(b)));
      assign next_flag_byte[b] = clear_this ? set_term[b] :
        (flag_byte[b] | set_term[b]);
    end
  endgenerate

  // Flags start clear and only the set terms raise them
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_byte <= {FLAG_BYTES{flag_bank_pkg::FLAG_RESET}};
    end else begin
      flag_byte <= next_flag_byte;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read answer

  logic [7:0] read_mux;

  // Reserved and vendor bytes 15 to 21, and every offset outside, read zero
  assign read_mux = is_flag_byte(read_addr) ? flag_byte[read_index] :
    flag_bank_pkg::RESERVED_READ;

  // The answer carries the flags as they stood before the read cleared them
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      read_data <= flag_bank_pkg::RESERVED_READ;
      read_valid <= 1'b0;
    end else begin
      read_valid <= read_strobe;
      if (read_strobe) begin
        read_data <= read_mux;
      end
    end
  end

endmodule
`default_nettype wire

// >>> rtl/threshold_compare.sv
// Module: compares one 16-bit measurement against its alarm and warning thresholds
`timescale 1ns/1ps
`default_nettype none
module threshold_compare #(
  parameter bit SIGNED_VALUE = 1'b0
) (
  // Value, thresholds and conditions
  monitor_cmp_if.compare bus
);

  logic over_alarm;
  logic under_alarm;
  logic over_warn;
  logic under_warn;

  // Same 16-bit format as the measurement; temperature is two's complement
  generate
    if (SIGNED_VALUE) begin : g_signed
      assign over_alarm = $signed(bus.value) >
        $signed(bus.threshold[flag_bank_pkg::HIGH_ALARM_BIT]);
      assign under_alarm = $signed(bus.value) <
        $signed(bus.threshold[flag_bank_pkg::LOW_ALARM_BIT]);
      assign over_warn = $signed(bus.value) >
        $signed(bus.threshold[flag_bank_pkg::HIGH_WARN_BIT]);
      assign under_warn = $signed(bus.value) <
        $signed(bus.threshold[flag_bank_pkg::LOW_WARN_BIT]);
    end else begin : g_unsigned
      assign over_alarm = bus.value > bus.threshold[flag_bank_pkg::HIGH_ALARM_BIT];
      assign under_alarm = bus.value < bus.threshold[flag_bank_pkg::LOW_ALARM_BIT];
      assign over_warn = bus.value > bus.threshold[flag_bank_pkg::HIGH_WARN_BIT];
      assign under_warn = bus.value < bus.threshold[flag_bank_pkg::LOW_WARN_BIT];
    end
  endgenerate

  // Nibble order: high alarm, low alarm, high warning, low warning
  assign bus.condition = {over_alarm, under_alarm, over_warn, under_warn};

endmodule
`default_nettype wire

// >>> shared/flag_bank_pkg.sv
// Package: map, field positions and sizes for the latched monitor flag bank
package flag_bank_pkg;

  // Byte offsets of the flag field in the management map
  localparam logic [7:0] TEMPERATURE_FLAGS_AND_INIT_DONE = 8'h06;
  localparam logic [7:0] SUPPLY_VOLTAGE_FLAGS = 8'h07;
  localparam logic [7:0] VENDOR_MODULE_FLAGS = 8'h08;
  localparam logic [7:0] RX_POWER_FLAGS_LANES_1_2 = 8'h09;
  localparam logic [7:0] RX_POWER_FLAGS_LANES_3_4 = 8'h0a;
  localparam logic [7:0] TX_BIAS_FLAGS_LANES_1_2 = 8'h0b;
  localparam logic [7:0] TX_BIAS_FLAGS_LANES_3_4 = 8'h0c;
  localparam logic [7:0] TX_POWER_FLAGS_LANES_1_2 = 8'h0d;
  localparam logic [7:0] TX_POWER_FLAGS_LANES_3_4 = 8'h0e;
  localparam logic [7:0] RESERVED_LANE_FLAG_SET_FOUR = 8'h0f;
  localparam logic [7:0] RESERVED_LANE_FLAG_SET_FIVE = 8'h11;
  localparam logic [7:0] VENDOR_LANE_FLAG_SET_SIX = 8'h13;
  localparam logic [7:0] VENDOR_FLAG_BYTE = 8'h15;

  // Flag bytes held in flip-flops: offsets 6 to 14
  localparam logic [7:0] FIRST_FLAG_BYTE = TEMPERATURE_FLAGS_AND_INIT_DONE;
  localparam logic [7:0] LAST_FLAG_BYTE = TX_POWER_FLAGS_LANES_3_4;
  localparam int FLAG_BYTES = 9;

  // Positions of the four conditions inside a nibble
  localparam int HIGH_ALARM_BIT = 3;
  localparam int LOW_ALARM_BIT = 2;
  localparam int HIGH_WARN_BIT = 1;
  localparam int LOW_WARN_BIT = 0;
  localparam int UPPER_NIBBLE_LSB = 4;
  localparam int INIT_DONE_BIT = 0;

  // Monitored quantities: temperature, supply, then four lanes of each kind
  localparam int LANES = 4;
  localparam int QUANTITIES = 2 + 3 * LANES;
  localparam int TEMPERATURE_Q = 0;
  localparam int SUPPLY_Q = 1;
  localparam int RX_POWER_Q = 2;
  localparam int TX_BIAS_Q = RX_POWER_Q + LANES;
  localparam int TX_POWER_Q = TX_BIAS_Q + LANES;
  localparam int VALUE_WIDTH = 16;

  // Reset values
  localparam logic [7:0] FLAG_RESET = 8'h00;
  localparam logic [7:0] RESERVED_READ = 8'h00;
  localparam logic [1:0] PIN_SYNC_RESET = 2'h0;

endpackage

// >>> shared/monitor_cmp_if.sv
// Interface: one monitored value, its four thresholds and the resulting conditions
`timescale 1ns/1ps
`default_nettype none
interface monitor_cmp_if;
  logic [flag_bank_pkg::VALUE_WIDTH-1:0] value;
  logic [3:0][flag_bank_pkg::VALUE_WIDTH-1:0] threshold;
  logic [3:0] condition;
  modport source (output value, output threshold, input condition);
  modport compare (input value, input threshold, output condition);
endinterface
`default_nettype wire

// >>> verification/flag_bank_asserts.sv
// Checker: timing and content of the flag bank read answers
`timescale 1ns/1ps
`default_nettype none
module flag_bank_asserts #(
  parameter int VALUE_WIDTH = 16
) (
  // Clock, reset and monitor inputs
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [VALUE_WIDTH-1:0] temperature_value,
  input wire logic [VALUE_WIDTH-1:0] supply_value,
  input wire logic [3:0][VALUE_WIDTH-1:0] temperature_threshold,
  input wire logic [3:0][VALUE_WIDTH-1:0] supply_threshold,
  input wire logic init_sequence_done,
  // Read port
  input wire logic read_strobe,
  input wire logic [7:0] read_addr,
  input wire logic [7:0] read_data,
  input wire logic read_valid
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic [1:0] up;
  // Conditions are ignored until the pin synchroniser has settled after reset
  wire ok = (up == 2'h3);
  wire t_hi = $signed(temperature_value) > $signed(temperature_threshold[3]);
  wire v_lo = supply_value < supply_threshold[2];
  wire v_any = v_lo || supply_value > supply_threshold[3] || supply_value > supply_threshold[1]
    || supply_value < supply_threshold[0];
  wire rd6 = read_strobe && read_addr == 8'h06;
  wire rd7 = read_strobe && read_addr == 8'h07;
  wire blank = read_addr == 8'h08 || read_addr > 8'h0e || read_addr < 8'h06;
  // Edges since reset release, saturating at three
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      up <= 2'h0;
    end else if (!ok) begin
      up <= up + 2'h1;
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  a_answer_next_cycle: assert property (read_strobe |=> read_valid)
    else $error("read not answered");
  a_no_stray_answer: assert property (read_valid |-> $past(read_strobe))
    else $error("answer without read");
  a_data_held: assert property (!read_strobe |=> $stable(read_data))
    else $error("read data moved without read");
  a_blank_zero: assert property (read_strobe && blank |=> read_data == 8'h00)
    else $error("vendor or reserved byte not zero");
  a_temp_reserved: assert property (rd6 |=> read_data[3:1] == 3'h0)
    else $error("byte 6 reserved bits set");
  a_supply_reserved: assert property (rd7 |=> read_data[3:0] == 4'h0)
    else $error("byte 7 reserved bits set");
  a_temp_high_latch: assert property (ok && t_hi ##1 rd6 |=> read_data[7])
    else $error("temperature high alarm missing");
  a_supply_low_latch: assert property (ok && v_lo ##1 rd7 |=> read_data[6])
    else $error("supply low alarm missing");
  a_init_sets: assert property (ok && $rose(init_sequence_done) ##1 rd6 |=> read_data[0])
    else $error("init done flag missing");
  a_read_clears: assert property (rd7 && !v_any ##1 rd7 |=> read_data == 8'h00)
    else $error("supply flags not cleared by read");
  c_temp_flag: cover property (rd6 ##1 read_data[7]);
  c_init_flag: cover property (rd6 ##1 read_data[0]);
  c_vendor_read: cover property (read_strobe && read_addr == 8'h15);
endmodule
bind monitor_flag_latch_bank flag_bank_asserts #(.VALUE_WIDTH(VALUE_WIDTH)) flag_bank_asserts_i (
  .clk(clk), .rst_n(rst_n), .temperature_value(temperature_value), .supply_value(supply_value),
  .temperature_threshold(temperature_threshold), .supply_threshold(supply_threshold),
  .init_sequence_done(init_sequence_done), .read_strobe(read_strobe), .read_addr(read_addr),
  .read_data(read_data), .read_valid(read_valid));
`default_nettype wire

// >>> verification/host_reader.sv
// Host model: byte reads over the flag bank read port
`timescale 1ns/1ps
`default_nettype none
module host_reader (
  // Clock
  input wire logic clk,
  // Read port
  output logic read_strobe,
  output logic [7:0] read_addr,
  input wire logic [7:0] read_data,
  input wire logic read_valid
);
  initial begin
    read_strobe = 1'b0;
    read_addr = 8'h00;
  end
  //////////////////////////////////////////////////////////////////////////////
  // Two back-to-back reads of one byte; an answer without valid comes back unknown
  // Answers are taken at the falling edge, where they have settled
  task automatic read_twice(input logic [7:0] a, output logic [7:0] d0, output logic [7:0] d1);
    @(posedge clk);
    read_strobe <= 1'b1;
    read_addr <= a;
    @(posedge clk);
    @(negedge clk);
    d0 = (read_valid === 1'b1) ? read_data : 8'hxx;
    @(posedge clk);
    read_strobe <= 1'b0;
    read_addr <= ~a; // Idle address never repeats the last one
    @(negedge clk);
    d1 = (read_valid === 1'b1) ? read_data : 8'hxx;
  endtask
endmodule
`default_nettype wire

// >>> verification/tb_top.sv
// Testbench: scenarios for the latched monitor flag bank
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic pin_n = 1'b1;
  logic init_done = 1'b0;
  logic [15:0] temp_v = 16'h0000;
  logic [15:0] sup_v = 16'h01f4;
  logic [3:0][15:0] rx_v = {4{16'h01f4}};
  logic [3:0][15:0] bias_v = {4{16'h01f4}};
  logic [3:0][15:0] txp_v = {4{16'h01f4}};
  logic [3:0][15:0] t_th = {16'h0064, 16'hff9c, 16'h0032, 16'hffce};
  logic [3:0][15:0] u_th = {16'h03e8, 16'h0064, 16'h0320, 16'h00c8};
  logic read_strobe;
  logic [7:0] read_addr;
  logic [7:0] read_data;
  logic read_valid;
  int errors = 0;
  int total_checks = 0;
  int cycles = 0;
  always #25 clk = ~clk;
  monitor_flag_latch_bank monitor_flag_latch_bank_i (.clk(clk), .rst_n(rst_n),
    .module_reset_pin_active_low(pin_n), .temperature_value(temp_v), .supply_value(sup_v),
    .rx_power_value(rx_v), .tx_bias_value(bias_v), .tx_power_value(txp_v),
    .temperature_threshold(t_th), .supply_threshold(u_th), .rx_power_threshold(u_th),
    .tx_bias_threshold(u_th), .tx_power_threshold(u_th), .init_sequence_done(init_done),
    .read_strobe(read_strobe), .read_addr(read_addr), .read_data(read_data),
    .read_valid(read_valid));
  host_reader host_reader_i (.clk(clk), .read_strobe(read_strobe), .read_addr(read_addr),
    .read_data(read_data), .read_valid(read_valid));
  //////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  // First answer must match; the reread finds the byte cleared
  task automatic chk_byte(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d0;
    logic [7:0] d1;
    host_reader_i.read_twice(a, d0, d1);
    check($sformatf("byte %h", a), exp, d0);
    check($sformatf("byte %h reread", a), 8'h00, d1);
  endtask
  task automatic t_defaults();
    for (int a = 4; a < 23; a++) chk_byte(8'(a), 8'h00);
    $display("defaults finished");
  endtask
  task automatic t_init();
    @(posedge clk);
    init_done <= 1'b1;
    chk_byte(8'h06, 8'h01);
    $display("init flag finished");
  endtask
  // Signed temperature and unsigned supply, high and low alarm with warning, then each warning alone
  task automatic t_module_flags();
    logic [15:0] tv[4] = '{16'h00c8, 16'hff38, 16'h004b, 16'hffb5};
    logic [15:0] sv[4] = '{16'h07d0, 16'h0032, 16'h0384, 16'h0096};
    logic [7:0] e[4] = '{8'ha0, 8'h50, 8'h20, 8'h10};
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      temp_v <= tv[i];
      sup_v <= sv[i];
      @(posedge clk);
      temp_v <= 16'h0000;
      sup_v <= 16'h01f4;
      chk_byte(8'h06, e[i]);
      chk_byte(8'h07, e[i]);
    end
    $display("module flags finished");
  endtask
  task automatic t_lanes();
    for (int k = 0; k < 3; k++) begin
      for (int l = 0; l < 4; l++) begin
        @(posedge clk);
        if (k == 0) rx_v[l] <= 16'h07d0;
        else if (k == 1) bias_v[l] <= 16'h07d0;
        else txp_v[l] <= 16'h07d0;
        @(posedge clk);
        rx_v <= {4{16'h01f4}};
        bias_v <= {4{16'h01f4}};
        txp_v <= {4{16'h01f4}};
        chk_byte(8'(9 + 2 * k + l / 2), l % 2 ? 8'h0a : 8'ha0);
      end
    end
    $display("lane flags finished");
  endtask
  task automatic t_pin_clear();
    @(posedge clk);
    temp_v <= 16'h00c8;
    @(posedge clk);
    temp_v <= 16'h0000;
    pin_n <= 1'b0;
    repeat (4) @(posedge clk);
    pin_n <= 1'b1;
    repeat (3) @(posedge clk);
    chk_byte(8'h06, 8'h00);
    $display("pin clear finished");
  endtask
  task automatic give_verdict();
    $display("checks %0d, errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    t_defaults();
    t_init();
    t_module_flags();
    t_pin_clear();
    t_lanes();
    give_verdict();
  end
  // Hang guard: the scenarios need well under a thousand cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      give_verdict();
    end
  end
endmodule
`default_nettype wire
